// ---- hdl/wire_link_pkg.sv ----
// Constants shared by the one-wire dimming link receiver and its FIFO.
// Assumes a single 50 MHz system clock; all times except the stream end maximum are converted to cycles here.
`default_nettype none

package wire_link_pkg;

  // ----------------------------------------------------------------------
  // Clock and times
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ                 = 50;
  localparam int DETECT_DELAY_TIME_US    = 100;
  localparam int DETECT_LOW_TIME_US      = 260;
  localparam int DETECT_PERIOD_US        = 1000;
  localparam int START_TIME_US           = 2;
  localparam int STREAM_END_TIME_MIN_US  = 2;
  localparam int STREAM_END_TIME_MAX_US  = 360;
  localparam int ACK_VALID_DELAY_US      = 2;
  localparam int ACK_DURATION_US         = 512;
  localparam int SHUTDOWN_LOW_US         = 2500;

  localparam int DETECT_DELAY_CYC  = DETECT_DELAY_TIME_US * CLK_MHZ;
  localparam int DETECT_LOW_CYC    = DETECT_LOW_TIME_US * CLK_MHZ;
  localparam int DETECT_PERIOD_CYC = DETECT_PERIOD_US * CLK_MHZ;
  localparam int START_CYC         = START_TIME_US * CLK_MHZ;
  localparam int END_MIN_CYC       = STREAM_END_TIME_MIN_US * CLK_MHZ;
  localparam int ACK_VALID_CYC     = ACK_VALID_DELAY_US * CLK_MHZ;
  localparam int ACK_DURATION_CYC  = ACK_DURATION_US * CLK_MHZ;
  localparam int SHUTDOWN_CYC      = SHUTDOWN_LOW_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Frame layout and reset values
  // ----------------------------------------------------------------------
  localparam int CMD_BITS      = 16;
  localparam int ACK_BIT_POS   = 15;
  localparam int CNT_W         = 18;
  localparam int FIFO_DEPTH    = 8;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_OFF, ST_DELAY, ST_WINDOW, ST_PWM, ST_IDLE, ST_BITS, ST_ACK
  } link_state_t;

endpackage

`default_nettype wire

// ---- hdl/word_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock, an asynchronous active-high reset and a clock enable.
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("word_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;

  wire full_w  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                 (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire empty_w = (wr_ptr_reg == rd_ptr_reg);
  wire push_w  = ce && in_valid && !full_w;
  wire pop_w   = ce && out_ready && !empty_w;

  assign in_ready  = !full_w;
  assign out_valid = !empty_w;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push_w) mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push_w) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop_w) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/one_wire_dimming_link.sv ----
// One-wire brightness command receiver on the enable pin, with open-drain acknowledge.
// Assumes the enable line is synchronous to SYS_CLK and pulled up by the host when acked.
//
// What this block does
// - Ignore the line for detection until 100 us after enable rises.
// - A detection pulse is a low of at least 260 us.
// - Detection period closes once the line is high 1 ms or more after enable rises; a pulse ending then still counts, later ones are ignored.
// - A stream opens with a start condition of at least 2 us.
// - A stream closes with an end condition of at least 2 us; the 360 us maximum is not checked.
// - Acknowledge is driven only when the ack request flag is one.
// - Acknowledge low appears within 2 us of stream end, lasts at most 512 us.
// - Without a valid selection pulse, fall back to pulse-width dimming.
// - Enable low longer than 2.5 ms shuts the link down.
`default_nettype none

module one_wire_dimming_link #(
  parameter int DETECT_PERIOD_CYCLES = wire_link_pkg::DETECT_PERIOD_CYC,
  parameter int DETECT_LOW_CYCLES    = wire_link_pkg::DETECT_LOW_CYC,
  parameter int DETECT_DELAY_CYCLES  = wire_link_pkg::DETECT_DELAY_CYC,
  parameter int ACK_CYCLES           = wire_link_pkg::ACK_DURATION_CYC,
  parameter int SHUTDOWN_CYCLES      = wire_link_pkg::SHUTDOWN_CYC,
  parameter int END_CYCLES           = wire_link_pkg::END_MIN_CYC,
  parameter int CMD_WIDTH            = wire_link_pkg::CMD_BITS
) (
  input  wire logic                 SYS_CLK,
  input  wire logic                 RESET,
  input  wire logic                 CLK_EN,
  input  wire logic                 EN_LINE_IN,
  output var  logic                 EN_LINE_OUT,
  output var  logic                 EN_LINE_OE,
  output var  logic                 ONE_WIRE_MODE,
  output var  logic                 PWM_MODE,
  output var  logic                 LINK_ACTIVE,
  output var  logic [CMD_WIDTH-1:0] CMD_DATA,
  output var  logic                 CMD_VALID,
  input  wire logic                 CMD_READY,
  output var  logic                 CMD_DROPPED
);

  localparam int W = wire_link_pkg::CNT_W;

  initial begin
    if (CMD_WIDTH != wire_link_pkg::CMD_BITS) $error("CMD_WIDTH must match the frame layout");
    if (DETECT_DELAY_CYCLES >= DETECT_PERIOD_CYCLES) $error("detection delay exceeds period");
    if (ACK_CYCLES < 2) $error("acknowledge too short for the phase counter");
    if (SHUTDOWN_CYCLES >= (1 << W) || DETECT_PERIOD_CYCLES >= (1 << W))
      $error("counter too narrow for the chosen times");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  wire_link_pkg::link_state_t state_reg;
  wire_link_pkg::link_state_t state_next;
  logic [W-1:0]           since_rise_reg;
  logic [W-1:0]           phase_cnt_reg;
  logic [W-1:0]           high_len_reg;
  logic                   line_d_reg;
  logic [CMD_WIDTH-1:0]   shift_reg;
  logic [5:0]             nbits_reg;
  logic                   ack_oe_reg;
  logic                   mode_one_reg;
  logic                   mode_pwm_reg;
  logic                   active_reg;
  logic                   dropped_reg;
  logic                   push_reg;
  logic [CMD_WIDTH-1:0]   push_data_reg;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [CMD_WIDTH-1:0]   fifo_out_data;

  function automatic logic reached(input logic [W-1:0] cnt, input int lim);
    return cnt >= W'(lim);
  endfunction

  wire rise_w      = EN_LINE_IN && !line_d_reg;
  wire fall_w      = !EN_LINE_IN && line_d_reg;
  wire low_long_w  = !EN_LINE_IN && reached(phase_cnt_reg, SHUTDOWN_CYCLES);
  // ratio decode: longer high than low gives a one.
  wire bit_val_w   = high_len_reg > phase_cnt_reg;
  // stream end: line held high past the end time after a full frame.
  wire end_seen_w  = EN_LINE_IN && reached(phase_cnt_reg, END_CYCLES)
                     && nbits_reg == 6'(CMD_WIDTH);
  // acknowledge only when the request flag is set.
  wire ack_req_w   = shift_reg[wire_link_pkg::ACK_BIT_POS];

  // ----------------------------------------------------------------------
  // Next-state decode
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      wire_link_pkg::ST_OFF:    if (rise_w) state_next = wire_link_pkg::ST_DELAY;
      wire_link_pkg::ST_DELAY:
        if (reached(since_rise_reg, DETECT_DELAY_CYCLES)) state_next = wire_link_pkg::ST_WINDOW;
      wire_link_pkg::ST_WINDOW: begin
        // low long enough selects one-wire mode
        if (rise_w && reached(phase_cnt_reg, DETECT_LOW_CYCLES))
          state_next = wire_link_pkg::ST_IDLE;
        // period closes; fall back to pulse width
        else if (reached(since_rise_reg, DETECT_PERIOD_CYCLES) && EN_LINE_IN)
          state_next = wire_link_pkg::ST_PWM;
      end
      wire_link_pkg::ST_PWM:    state_next = wire_link_pkg::ST_PWM;
      // a falling edge after the start-condition high opens the stream
      wire_link_pkg::ST_IDLE:
        if (fall_w && reached(phase_cnt_reg, wire_link_pkg::START_CYC))
          state_next = wire_link_pkg::ST_BITS;
      wire_link_pkg::ST_BITS: begin
        if (end_seen_w) state_next = ack_req_w ? wire_link_pkg::ST_ACK : wire_link_pkg::ST_IDLE;
      end
      // ack released after its duration
      // The phase counter restarts again when our own pull drags the line low, so the
      // limit is two short; the pull then lasts exactly ACK_CYCLES and never overruns.
      wire_link_pkg::ST_ACK:
        if (reached(phase_cnt_reg, ACK_CYCLES - 2)) state_next = wire_link_pkg::ST_IDLE;
      default:                  state_next = wire_link_pkg::ST_OFF;
    endcase
    // long low shuts the link down
    if (low_long_w && state_reg != wire_link_pkg::ST_ACK) state_next = wire_link_pkg::ST_OFF;
  end

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  wire phase_clr_w = (EN_LINE_IN != line_d_reg) || (state_next != state_reg);

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state_reg      <= wire_link_pkg::ST_OFF;
      line_d_reg     <= 1'b0;
      since_rise_reg <= '0;
      phase_cnt_reg  <= '0;
      high_len_reg   <= '0;
    end else if (CLK_EN) begin
      state_reg      <= state_next;
      line_d_reg     <= EN_LINE_IN;
      since_rise_reg <= (state_reg == wire_link_pkg::ST_OFF) ? '0 :
                        (reached(since_rise_reg, SHUTDOWN_CYCLES) ? since_rise_reg
                                                                 : since_rise_reg + 1'b1);
      phase_cnt_reg  <= phase_clr_w ? '0 :
                        (reached(phase_cnt_reg, SHUTDOWN_CYCLES) ? phase_cnt_reg
                                                                : phase_cnt_reg + 1'b1);
      if (fall_w) high_len_reg <= phase_cnt_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Bit shifting and frame capture
  // ----------------------------------------------------------------------
  // A bit completes on each rising edge: the low just ended is compared to the high before it.
  wire bit_done_w = state_reg == wire_link_pkg::ST_BITS && rise_w;

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      shift_reg     <= wire_link_pkg::CMD_RESET;
      nbits_reg     <= '0;
      push_reg      <= 1'b0;
      push_data_reg <= wire_link_pkg::CMD_RESET;
      dropped_reg   <= 1'b0;
    end else if (CLK_EN) begin
      push_reg <= 1'b0;
      if (state_reg != wire_link_pkg::ST_BITS) nbits_reg <= '0;
      else if (bit_done_w && nbits_reg != 6'(CMD_WIDTH)) begin
        // shift in the decoded bit, first bit most significant
        shift_reg <= {shift_reg[CMD_WIDTH-2:0], bit_val_w};
        nbits_reg <= nbits_reg + 1'b1;
      end
      if (state_reg == wire_link_pkg::ST_BITS && end_seen_w) begin
        push_reg      <= 1'b1;
        push_data_reg <= shift_reg;
      end
      // Full FIFO: the frame is lost rather than stalling a host that cannot wait.
      dropped_reg <= push_reg && !fifo_in_ready;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ack_oe_reg   <= 1'b0;
      mode_one_reg <= 1'b0;
      mode_pwm_reg <= 1'b0;
      active_reg   <= 1'b0;
    end else if (CLK_EN) begin
      // pull low the cycle after the end is seen, well inside 2 us
      ack_oe_reg   <= state_next == wire_link_pkg::ST_ACK;
      mode_one_reg <= state_next inside {wire_link_pkg::ST_IDLE, wire_link_pkg::ST_BITS,
                                          wire_link_pkg::ST_ACK};
      mode_pwm_reg <= state_next == wire_link_pkg::ST_PWM;
      active_reg   <= state_next != wire_link_pkg::ST_OFF;
    end
  end

  word_fifo #(.WIDTH(CMD_WIDTH), .DEPTH(wire_link_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (SYS_CLK),
    .rst       (RESET),
    .ce        (CLK_EN),
    .in_data   (push_data_reg),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (CMD_READY)
  );

  assign EN_LINE_OUT   = 1'b0;
  assign EN_LINE_OE    = ack_oe_reg;
  assign ONE_WIRE_MODE = mode_one_reg;
  assign PWM_MODE      = mode_pwm_reg;
  assign LINK_ACTIVE   = active_reg;
  assign CMD_DATA      = fifo_out_data;
  assign CMD_VALID     = fifo_out_valid;
  assign CMD_DROPPED   = dropped_reg;

endmodule

`default_nettype wire

// ---- verif/link_checker_assertions.sv ----
// Port-level checks on the one-wire link receiver, bound onto it below.
// Assumes the same shortened cycle parameters as the receiver it watches.
`default_nettype none
module link_checker #(
  parameter int DETECT_PERIOD_CYCLES = 1000,
  parameter int DETECT_LOW_CYCLES    = 260,
  parameter int ACK_CYCLES           = 200,
  parameter int SHUTDOWN_CYCLES      = 2000,
  parameter int END_CYCLES           = 100
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic EN_LINE_IN,
  input wire logic EN_LINE_OE,
  input wire logic ONE_WIRE_MODE,
  input wire logic PWM_MODE,
  input wire logic LINK_ACTIVE,
  input wire logic CMD_DROPPED
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Run lengths of line levels and of the acknowledge
  // ------------------------------------------------------------
  int low_run, hi_run, oe_run, up_cnt, last_low;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      low_run  <= 0;
      hi_run   <= 0;
      oe_run   <= 0;
      up_cnt   <= 0;
      last_low <= 0;
    end else begin
      low_run <= EN_LINE_IN ? 0 : low_run + 1;
      hi_run  <= EN_LINE_IN ? hi_run + 1 : 0;
      oe_run  <= EN_LINE_OE ? oe_run + 1 : 0;
      // Time since wake-up; the slack below covers the receiver's input stages.
      up_cnt  <= LINK_ACTIVE ? up_cnt + 1 : 0;
      if (EN_LINE_IN && low_run > 0) begin
        last_low <= low_run;
      end
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  property p_ack_len; $fell(EN_LINE_OE) |-> oe_run == ACK_CYCLES; endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
  property p_ack_start;
    $rose(EN_LINE_OE) |-> $past(hi_run) inside {[END_CYCLES - 1:END_CYCLES + 100]};
  endproperty
  a_ack_start: assert property (p_ack_start) else $error("ack start off");
  property p_ack_mode; $rose(EN_LINE_OE) |-> ONE_WIRE_MODE && LINK_ACTIVE; endproperty
  a_ack_mode: assert property (p_ack_mode) else $error("ack outside link");
  property p_modes; !(ONE_WIRE_MODE && PWM_MODE); endproperty
  a_modes: assert property (p_modes) else $error("both modes set");
  property p_pwm_time;
    $rose(PWM_MODE) |-> up_cnt inside {[DETECT_PERIOD_CYCLES - 4:DETECT_PERIOD_CYCLES + 4]};
  endproperty
  a_pwm_time: assert property (p_pwm_time) else $error("fallback mistimed");
  property p_sel;
    $rose(ONE_WIRE_MODE) |-> last_low >= DETECT_LOW_CYCLES && up_cnt <= DETECT_PERIOD_CYCLES + 4;
  endproperty
  a_sel: assert property (p_sel) else $error("bad selection");
  property p_shut;
    low_run >= SHUTDOWN_CYCLES + 4 |-> !LINK_ACTIVE && !ONE_WIRE_MODE && !PWM_MODE;
  endproperty
  a_shut: assert property (p_shut) else $error("no shutdown");
  property p_drop; CMD_DROPPED |=> !CMD_DROPPED; endproperty
  a_drop: assert property (p_drop) else $error("drop flag stuck");
endmodule

bind one_wire_dimming_link link_checker #(
  .DETECT_PERIOD_CYCLES(DETECT_PERIOD_CYCLES), .DETECT_LOW_CYCLES(DETECT_LOW_CYCLES),
  .ACK_CYCLES(ACK_CYCLES), .SHUTDOWN_CYCLES(SHUTDOWN_CYCLES), .END_CYCLES(END_CYCLES)
) u_link_checker (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .EN_LINE_IN(EN_LINE_IN), .EN_LINE_OE(EN_LINE_OE),
  .ONE_WIRE_MODE(ONE_WIRE_MODE), .PWM_MODE(PWM_MODE), .LINK_ACTIVE(LINK_ACTIVE),
  .CMD_DROPPED(CMD_DROPPED)
);
`default_nettype wire

// ---- verif/host_line_model.sv ----
// Host side of the enable line: open-drain driver plus pull-up.
// Assumes its tasks are called from the bench at falling clock edges.
`default_nettype none
module host_line_model (
  input  wire logic clk,
  input  wire logic dev_pull,
  output wire logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  // The host starts out holding the line low; the bench releases it to enable the link.
  logic host_low = 1'b1;
  assign line = (host_low || dev_pull) ? 1'b0 : 1'b1;
  task automatic wait_cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse_low(int n);
    host_low = 1'b1;
    wait_cyc(n);
    host_low = 1'b0;
  endtask
  // framed bit timing
  // A leading zero gets a very long low so it outlasts any idle high before it.
  task automatic send_word(logic [15:0] w);
    wait_cyc(110);
    for (int i = 15; i >= 0; i--) begin
      pulse_low(w[i] ? 20 : (i == 15 ? 1500 : 80));
      wait_cyc(i == 0 ? 130 : 40);
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/one_wire_dimming_link_test.sv ----
// Self-checking bench for the one-wire link receiver with a host line model.
// Assumes the checker is bound in and shortened cycle parameters are used.
`default_nettype none
module one_wire_dimming_link_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOWC = 260;
  localparam int ACKC = 200;
  localparam int PERC = 1000;
  localparam int DELC = 100;
  localparam int SHUTC = 2000;
  localparam int ENDC = 100;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        cmd_ready = 1'b0;
  logic        clk_en = 1'b1;
  logic        line_oe, line_out, one_wire, pwm, active, cmd_valid, dropped;
  logic [15:0] cmd_data;
  wire         line;
  int          errors = 0, cmp_count = 0, oe_cnt = 0, drop_cnt = 0;
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (line_oe === 1'b1) oe_cnt++;
    if (dropped === 1'b1) drop_cnt++;
  end
  host_line_model hl (.clk(sys_clk), .dev_pull(line_oe), .line(line));
  one_wire_dimming_link #(
    .DETECT_PERIOD_CYCLES(PERC), .DETECT_LOW_CYCLES(LOWC), .DETECT_DELAY_CYCLES(DELC),
    .ACK_CYCLES(ACKC), .SHUTDOWN_CYCLES(SHUTC), .END_CYCLES(ENDC)
  ) DUT (
    .SYS_CLK(sys_clk), .RESET(reset), .CLK_EN(clk_en), .EN_LINE_IN(line), .EN_LINE_OUT(line_out),
    .EN_LINE_OE(line_oe), .ONE_WIRE_MODE(one_wire), .PWM_MODE(pwm), .LINK_ACTIVE(active),
    .CMD_DATA(cmd_data), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_DROPPED(dropped)
  );
  task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  task automatic pop_word(logic [15:0] exp);
    chk(16'(cmd_valid), 16'h0001, "no word");
    chk(cmd_data, exp, "word");
    cmd_ready = 1'b1;
    @(negedge sys_clk);
    cmd_ready = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic t_select;
    hl.host_low = 1'b0;
    hl.wait_cyc(150);
    hl.pulse_low(LOWC + 10);
    hl.wait_cyc(10);
    chk(16'(one_wire), 16'h0001, "not selected");
    chk(16'(line_out), 16'h0000, "line data");
    hl.wait_cyc(700);
    chk(16'(pwm), 16'h0000, "fallback");
    $display("test select done");
  endtask
  task automatic t_frames;
    logic [15:0] w [4] = '{16'h8001, 16'h7ffe, 16'hffff, 16'h0000};
    foreach (w[i]) begin
      oe_cnt = 0;
      hl.send_word(w[i]);
      hl.wait_cyc(250);
      pop_word(w[i]);
      chk(16'(oe_cnt), w[i][15] ? 16'(ACKC) : 16'h0000, "ack");
    end
    $display("test frames done");
  endtask
  // A whole frame sent while the clock enable is low must leave no trace.
  task automatic t_freeze;
    oe_cnt = 0;
    clk_en = 1'b0;
    hl.send_word(16'h8001);
    clk_en = 1'b1;
    hl.wait_cyc(250);
    chk(16'({cmd_valid, one_wire}), 16'h0001, "frozen frame taken");
    chk(16'(oe_cnt), 16'h0000, "frozen ack");
    $display("test freeze done");
  endtask
  task automatic t_fifo_full;
    drop_cnt = 0;
    for (int i = 0; i < 9; i++) hl.send_word(16'h0100 + 16'(i));
    hl.wait_cyc(5);
    chk(16'(drop_cnt), 16'h0001, "drops");
    for (int i = 0; i < 8; i++) pop_word(16'h0100 + 16'(i));
    chk(16'(cmd_valid), 16'h0000, "not empty");
    $display("test fifo done");
  endtask
  task automatic t_fallback;
    hl.host_low = 1'b1;
    hl.wait_cyc(2100);
    chk(16'({active, one_wire}), 16'h0000, "no shutdown");
    hl.host_low = 1'b0;
    hl.wait_cyc(10);
    hl.pulse_low(50);
    hl.wait_cyc(90);
    hl.pulse_low(LOWC - 10);
    hl.wait_cyc(650);
    chk(16'({pwm, one_wire}), 16'h0002, "short pulse");
    hl.pulse_low(LOWC + 10);
    hl.wait_cyc(10);
    chk(16'(one_wire), 16'h0000, "late pulse");
    $display("test fallback done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    hl.wait_cyc(5);
    t_select();
    t_frames();
    t_freeze();
    t_fifo_full();
    t_fallback();
    close_out();
  end
  // The scenarios need about 50000 cycles; twice that means a hang.
  initial begin
    #2000000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end
endmodule
`default_nettype wire
